//--- logic/rdpc_pin_control.sv
/*
 * Pin-level control of an eight-channel load driver: channel command
 * mapping, operating mode selection from the idle and input pins, the
 * hardware reset and output-kill pins, and a pin level report.
 * Assumes pins already at logic levels (pull resistors modelled outside),
 * one 50 MHz clock and a simple strobe register port.
 */
// Behaviour
// - Out of reset input A drives channel 2, input B channel 3.
// - Each parallel input has a writable channel select register.
// - Channel command is OR of on bit, mapped PWM and mapped inputs.
// - Both input levels readable in pin report, also in limp-home.
// - Idle low with an input high enters limp-home, default channels on.
// - Idle low with both inputs low enters sleep mode.
// - Entering sleep returns every writable register to default.
// - Sleep disables both supply undervoltage detectors.
// - Sleep refuses register access and keeps serial output off.
// - Unmasked low reset pin holds reset, channels off, registers default except unmask bits.
// - Reset pin ignored until software unmasks it.
// - Unmasked high kill pin disables all channels; low leaves them.
// - Kill pin ignored until software unmasks it.
// - Kill pin level readable in pin report.
// - Open kill and reset pins read as asserted.
// - Without safety pins, unmask bits are reserved and stay zero.
`timescale 1ns/1ps
`include "rdpc_params.svh"

module rdpc_pin_control #(
    parameter int NUM_CH = 8,
    parameter int ADDR_W = 8,
    parameter bit HAS_SAFETY_PINS = 1'b1,
    parameter int IDLE_FLT_CYC = `RDPC_IDLE_FLT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [31:0] rd_data_o,
    input wire logic parallel_cmd_input_a_i,
    input wire logic parallel_cmd_input_b_i,
    input wire logic idle_pin_i,
    input wire logic hardware_reset_pin_n_i,
    input wire logic output_kill_pin_i,
    input wire logic serial_cs_n_i,
    input wire logic [1:0] pwm_gen_i,
    output logic [NUM_CH-1:0] ch_drive_o,
    output logic [3:0] mode_o,
    output logic serial_out_en_o,
    output logic uv_io_det_en_o,
    output logic uv_batt_det_en_o,
    output logic internal_reset_o
);

    localparam int CNT_W = $clog2(IDLE_FLT_CYC + 1);
    localparam logic [NUM_CH-1:0] MAP_A_DEF = NUM_CH'(`RDPC_RST_MAP_A);
    localparam logic [NUM_CH-1:0] MAP_B_DEF = NUM_CH'(`RDPC_RST_MAP_B);
    localparam logic [NUM_CH-1:0] ON_DEF = NUM_CH'(`RDPC_RST_ON_CMD);
    localparam logic [NUM_CH-1:0] PWM_DEF = NUM_CH'(`RDPC_RST_MAP_PWM);

    initial begin
        if (NUM_CH < 4 || NUM_CH > 32) begin
            $error("NUM_CH must lie in 4..32");
        end
        if (ADDR_W < 5 || ADDR_W > 8) begin
            $error("ADDR_W must lie in 5..8");
        end
        if (IDLE_FLT_CYC < 1) begin
            $error("IDLE_FLT_CYC must be at least 1");
        end
        if (`RDPC_PIN_W != 5) begin
            $error("Pin report layout expects five pins");
        end
    end

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                     input logic [7:0] off);
        reg_hit = (a == ADDR_W'(off));
    endfunction

    // Every mode but sleep keeps detectors and serial port alive
    function automatic logic mode_awake(input rdpc_pkg::rdpc_mode_type m);
        mode_awake = (m != rdpc_pkg::RDPC_SLEEP);
    endfunction

    // Pin synchroniser
    logic [`RDPC_PIN_W-1:0] pin_raw;
    logic [`RDPC_PIN_W-1:0] sync1_r;
    logic [`RDPC_PIN_W-1:0] sync2_r;

    assign pin_raw = {hardware_reset_pin_n_i, idle_pin_i, output_kill_pin_i,
                      parallel_cmd_input_b_i, parallel_cmd_input_a_i};

    // two flop synchroniser
    // Reset levels match open pins: kill high, reset pin low.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_r <= `RDPC_RST_PIN_LEVEL;
            sync2_r <= `RDPC_RST_PIN_LEVEL;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    logic pin_a;
    logic pin_b;
    logic pin_kill;
    logic pin_rst_n;

    assign pin_a = sync2_r[`RDPC_PIN_A];
    assign pin_b = sync2_r[`RDPC_PIN_B];
    assign pin_kill = sync2_r[`RDPC_PIN_KILL];
    assign pin_rst_n = sync2_r[`RDPC_PIN_RST_N];

    // Idle filter: short glitches on the idle pin do not change mode
    logic idle_flt_r;
    logic [CNT_W-1:0] idle_cnt_r;

    // idle level accepted after filter time
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idle_flt_r <= 1'b0;
            idle_cnt_r <= '0;
        end else if (sync2_r[`RDPC_PIN_IDLE] == idle_flt_r) begin
            idle_cnt_r <= '0;
        end else if (idle_cnt_r == CNT_W'(IDLE_FLT_CYC - 1)) begin
            idle_flt_r <= sync2_r[`RDPC_PIN_IDLE];
            idle_cnt_r <= '0;
        end else begin
            idle_cnt_r <= idle_cnt_r + CNT_W'(1);
        end
    end

    // Registers
    logic [NUM_CH-1:0] on_cmd_r;
    logic [NUM_CH-1:0] input_a_channel_select_r;
    logic [NUM_CH-1:0] input_b_channel_select_r;
    logic [NUM_CH-1:0] map_pwm0_r;
    logic [NUM_CH-1:0] map_pwm1_r;
    logic rst_unmask_r;
    logic kill_unmask_r;
    rdpc_pkg::rdpc_mode_type mode_r;
    rdpc_pkg::rdpc_mode_type mode_nxt;

    logic sleep;
    logic pin_rst_act;
    logic kill_act;
    logic hold_default;
    logic bus_wr;
    logic bus_rd;

    assign sleep = ~mode_awake(mode_r);
    // open reset pin reads low, so asserted
    assign pin_rst_act = rst_unmask_r & ~pin_rst_n;
    assign kill_act = kill_unmask_r & pin_kill;
    assign hold_default = sleep | pin_rst_act;
    assign bus_wr = wr_en_i & ~sleep;
    assign bus_rd = rd_en_i & ~sleep;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            on_cmd_r <= ON_DEF;
            input_a_channel_select_r <= MAP_A_DEF;
            input_b_channel_select_r <= MAP_B_DEF;
            map_pwm0_r <= PWM_DEF;
            map_pwm1_r <= PWM_DEF;
        end else if (hold_default) begin
            on_cmd_r <= ON_DEF;
            input_a_channel_select_r <= MAP_A_DEF;
            input_b_channel_select_r <= MAP_B_DEF;
            map_pwm0_r <= PWM_DEF;
            map_pwm1_r <= PWM_DEF;
        end else if (bus_wr) begin
            if (reg_hit(addr_i, `RDPC_OFF_ON_CMD)) begin
                on_cmd_r <= wr_data_i[NUM_CH-1:0];
            end else if (reg_hit(addr_i, `RDPC_OFF_MAP_A)) begin
                input_a_channel_select_r <= wr_data_i[NUM_CH-1:0];
            end else if (reg_hit(addr_i, `RDPC_OFF_MAP_B)) begin
                input_b_channel_select_r <= wr_data_i[NUM_CH-1:0];
            end else if (reg_hit(addr_i, `RDPC_OFF_MAP_PWM0)) begin
                map_pwm0_r <= wr_data_i[NUM_CH-1:0];
            end else if (reg_hit(addr_i, `RDPC_OFF_MAP_PWM1)) begin
                map_pwm1_r <= wr_data_i[NUM_CH-1:0];
            end
        end
    end

    // Unmask bits survive the pin reset, else the pin would unmask itself
    // away after one cycle and could never hold reset.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_unmask_r <= 1'b0;
            kill_unmask_r <= 1'b0;
        end else if (sleep) begin
            rst_unmask_r <= 1'b0;
            kill_unmask_r <= 1'b0;
        end else if (bus_wr && reg_hit(addr_i, `RDPC_OFF_CTRL)) begin
            rst_unmask_r <= HAS_SAFETY_PINS &
                            wr_data_i[`RDPC_CTRL_RST_UNMASK];
            kill_unmask_r <= HAS_SAFETY_PINS &
                             wr_data_i[`RDPC_CTRL_KILL_UNMASK];
        end
    end

    // Channel command
    logic [NUM_CH-1:0] cmd;
    logic [NUM_CH-1:0] limp_cmd;

    assign cmd = on_cmd_r
               | (map_pwm0_r & {NUM_CH{pwm_gen_i[0]}})
               | (map_pwm1_r & {NUM_CH{pwm_gen_i[1]}})
               | (input_a_channel_select_r & {NUM_CH{pin_a}})
               | (input_b_channel_select_r & {NUM_CH{pin_b}});

    // Limp-home ignores the select registers: the host may have failed,
    // so only the fixed default channels may come on.
    // limp-home uses default channels
    assign limp_cmd = (MAP_A_DEF & {NUM_CH{pin_a}})
                    | (MAP_B_DEF & {NUM_CH{pin_b}});

    always_comb begin
        if (idle_flt_r) begin
            mode_nxt = (|cmd) ? rdpc_pkg::RDPC_ACTIVE : rdpc_pkg::RDPC_IDLE;
        end else if (pin_a || pin_b) begin
            mode_nxt = rdpc_pkg::RDPC_LIMP;
        end else begin
            mode_nxt = rdpc_pkg::RDPC_SLEEP;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_r <= rdpc_pkg::RDPC_SLEEP;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Channel outputs
    logic [NUM_CH-1:0] drive_nxt;

    always_comb begin
        drive_nxt = '0;
        case (mode_r)
            rdpc_pkg::RDPC_ACTIVE: begin
                drive_nxt = cmd;
            end
            rdpc_pkg::RDPC_LIMP: begin
                drive_nxt = limp_cmd;
            end
            default: begin
                drive_nxt = '0;
            end
        endcase
        // pin reset and kill force off
        if (pin_rst_act || kill_act) begin
            drive_nxt = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ch_drive_o <= '0;
        end else begin
            ch_drive_o <= drive_nxt;
        end
    end

    // Mode side effects
    // Enables follow the next mode, so they drop with mode_o at sleep entry
    logic awake_nxt;

    assign awake_nxt = mode_awake(mode_nxt);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_o <= rdpc_pkg::RDPC_SLEEP;
            uv_io_det_en_o <= 1'b0;
            uv_batt_det_en_o <= 1'b0;
            serial_out_en_o <= 1'b0;
            internal_reset_o <= 1'b0;
        end else begin
            mode_o <= mode_nxt;
            uv_io_det_en_o <= awake_nxt;
            uv_batt_det_en_o <= awake_nxt;
            // Chip select is taken raw: it only gates an output enable
            // serial output stays off in sleep
            serial_out_en_o <= ~serial_cs_n_i & awake_nxt;
            internal_reset_o <= pin_rst_act;
        end
    end

    // Read port
    // Pin report shows synchronised levels, two cycles behind the pins;
    // upper bits of every word read zero.
    logic [31:0] rd_nxt;

    always_comb begin
        rd_nxt = '0;
        if (!bus_rd) begin
            rd_nxt = '0;
        end else if (reg_hit(addr_i, `RDPC_OFF_ON_CMD)) begin
            rd_nxt[NUM_CH-1:0] = on_cmd_r;
        end else if (reg_hit(addr_i, `RDPC_OFF_MAP_A)) begin
            rd_nxt[NUM_CH-1:0] = input_a_channel_select_r;
        end else if (reg_hit(addr_i, `RDPC_OFF_MAP_B)) begin
            rd_nxt[NUM_CH-1:0] = input_b_channel_select_r;
        end else if (reg_hit(addr_i, `RDPC_OFF_MAP_PWM0)) begin
            rd_nxt[NUM_CH-1:0] = map_pwm0_r;
        end else if (reg_hit(addr_i, `RDPC_OFF_MAP_PWM1)) begin
            rd_nxt[NUM_CH-1:0] = map_pwm1_r;
        end else if (reg_hit(addr_i, `RDPC_OFF_CTRL)) begin
            rd_nxt[`RDPC_CTRL_RST_UNMASK] = rst_unmask_r;
            rd_nxt[`RDPC_CTRL_KILL_UNMASK] = kill_unmask_r;
        end else if (reg_hit(addr_i, `RDPC_OFF_PIN_LEVEL)) begin
            // live pin levels in every mode but sleep, where reads return zero
            rd_nxt[`RDPC_PIN_W-1:0] = sync2_r;
        end else if (reg_hit(addr_i, `RDPC_OFF_MODE)) begin
            rd_nxt[3:0] = mode_r;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= rd_nxt;
        end
    end

endmodule

//--- logic/rdpc_params.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * relay driver pin control block.
 * Assumes a byte-addressed register port with one 32-bit word per register.
 */
`ifndef RDPC_PARAMS_SVH
`define RDPC_PARAMS_SVH

`define RDPC_OFF_ON_CMD 8'h00
`define RDPC_OFF_MAP_A 8'h04
`define RDPC_OFF_MAP_B 8'h08
`define RDPC_OFF_MAP_PWM0 8'h0c
`define RDPC_OFF_MAP_PWM1 8'h10
`define RDPC_OFF_CTRL 8'h14
`define RDPC_OFF_PIN_LEVEL 8'h18
`define RDPC_OFF_MODE 8'h1c

`define RDPC_RST_ON_CMD 8'h00
`define RDPC_RST_MAP_A 8'h04
`define RDPC_RST_MAP_B 8'h08
`define RDPC_RST_MAP_PWM 8'h00
`define RDPC_RST_PIN_LEVEL 5'h04

`define RDPC_CTRL_RST_UNMASK 0
`define RDPC_CTRL_KILL_UNMASK 1

`define RDPC_PIN_A 0
`define RDPC_PIN_B 1
`define RDPC_PIN_KILL 2
`define RDPC_PIN_IDLE 3
`define RDPC_PIN_RST_N 4
`define RDPC_PIN_W 5

`define RDPC_CLK_PERIOD_NS 20
`define RDPC_IDLE_FLT_NS 1000
`define RDPC_IDLE_FLT_CYC \
    ((`RDPC_IDLE_FLT_NS + `RDPC_CLK_PERIOD_NS - 1) / `RDPC_CLK_PERIOD_NS)

`endif

//--- logic/rdpc_pkg.sv
/*
 * Types of the relay driver pin control block.
 * Assumes the constants header is used alongside for numbers.
 */
package rdpc_pkg;

    typedef enum logic [3:0] {
        RDPC_SLEEP = 4'h1,
        RDPC_IDLE = 4'h2,
        RDPC_ACTIVE = 4'h4,
        RDPC_LIMP = 4'h8
    } rdpc_mode_type;

endpackage

//--- dv/rdpc_monitor.sv
/* Port checker of the pin control block.
   Assumes bind onto rdpc_pin_control, one clock domain. */
`timescale 1ns/1ps
module rdpc_monitor #(parameter int NUM_CH = 8) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic rd_en_i,
    input wire logic [31:0] rd_data_o,
    input wire logic parallel_cmd_input_a_i,
    input wire logic parallel_cmd_input_b_i,
    input wire logic idle_pin_i,
    input wire logic hardware_reset_pin_n_i,
    input wire logic [NUM_CH-1:0] ch_drive_o,
    input wire logic [3:0] mode_o,
    input wire logic serial_out_en_o,
    input wire logic uv_io_det_en_o,
    input wire logic uv_batt_det_en_o,
    input wire logic internal_reset_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_sleep_uv_off:
        assert property (mode_o == 4'h1 |->
            !uv_io_det_en_o && !uv_batt_det_en_o)
        else $error("detector enabled in sleep");
    a_sleep_no_serial:
        assert property (mode_o == 4'h1 |-> !serial_out_en_o)
        else $error("serial output enabled in sleep");
    a_sleep_read_zero:
        assert property ($past(rd_en_i) && $past(mode_o) == 4'h1 |->
            rd_data_o == 32'h0) else $error("read answered in sleep");
    a_reset_chan_off:
        assert property (internal_reset_o |-> ch_drive_o == '0)
        else $error("channel on while reset held");
    a_reset_pin_high:
        assert property (hardware_reset_pin_n_i [*4] |=> !internal_reset_o)
        else $error("reset held with pin high");
    a_sleep_entry:
        assert property ((!idle_pin_i && !parallel_cmd_input_a_i &&
            !parallel_cmd_input_b_i && hardware_reset_pin_n_i) [*8] |->
            ##2 mode_o == 4'h1 && ch_drive_o == '0)
            else $error("sleep not entered");
    a_limp_entry:
        assert property ((!idle_pin_i && parallel_cmd_input_a_i &&
            hardware_reset_pin_n_i) [*8] |-> ##2 mode_o == 4'h8)
        else $error("limp-home not entered");
    a_limp_default_ch:
        assert property (mode_o == 4'h8 [*2] |-> (ch_drive_o & ~8'h0c) == 0)
        else $error("limp-home drives a non-default channel");
endmodule

bind rdpc_pin_control rdpc_monitor #(.NUM_CH(NUM_CH)) rdpc_monitor_inst (
    .clk_i, .rst_n_i, .rd_en_i, .rd_data_o, .parallel_cmd_input_a_i,
    .parallel_cmd_input_b_i,
    .idle_pin_i, .hardware_reset_pin_n_i, .ch_drive_o, .mode_o,
    .serial_out_en_o, .uv_io_det_en_o, .uv_batt_det_en_o,
    .internal_reset_o);

//--- dv/rdpc_host_model.sv
/* Host side of the control pins, driven from bench requests.
   Assumes one clock; pins change just after a rising edge. */
`timescale 1ns/1ps
module rdpc_host_model #(parameter int HOLD = 8) (
    input wire logic clk_i,
    input wire logic idle_req_i,
    input wire logic [1:0] in_req_i,
    input wire logic kill_req_i,
    input wire logic rst_req_i,
    input wire logic cs_req_i,
    output logic idle_pin_o,
    output logic [1:0] in_pin_o,
    output logic kill_pin_o,
    output logic rst_pin_n_o,
    output logic cs_n_o
);
    int hold_cnt = 0;
    initial begin
        idle_pin_o = 1'b0;
        in_pin_o = 2'h0;
        kill_pin_o = 1'b0;
        rst_pin_n_o = 1'b1;
        cs_n_o = 1'b1;
    end
    always @(posedge clk_i) begin
        if (hold_cnt < HOLD) begin
            hold_cnt <= hold_cnt + 1;
        end else if (idle_req_i != idle_pin_o) begin
            idle_pin_o <= idle_req_i;
            hold_cnt <= 0;
        end
    end
    always @(posedge clk_i) begin
        in_pin_o <= in_req_i;
        kill_pin_o <= kill_req_i;
        rst_pin_n_o <= !rst_req_i;
        cs_n_o <= !cs_req_i;
    end
endmodule

//--- dv/test_rdpc_pin_control.sv
/* Self-checking bench of the pin control block.
   Assumes the host model drives the pins, bench drives the port. */
`timescale 1ns/1ps
`include "rdpc_params.svh"
module test_rdpc_pin_control;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wr_data_i = 32'h0;
    logic wr_en_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic [31:0] rd_data_o;
    logic idle_req = 1'b0;
    logic kill_req = 1'b0;
    logic rst_req = 1'b0;
    logic cs_req = 1'b0;
    logic [1:0] in_req = 2'h0;
    logic [1:0] pwm = 2'h0;
    logic idle_pin, kill_pin, rst_pin_n, cs_n;
    logic [1:0] in_pin;
    logic [7:0] ch, on_bits, ch_lite;
    logic [3:0] mode;
    logic sout_en, uv_io, uv_batt, int_rst, int_rst_lite;
    logic [31:0] exp_q[$];
    logic rd_seen = 1'b0;
    int err_count = 0;
    int comparisons = 0;
    int seed = 78765;

    always #10 clk_i = ~clk_i;

    rdpc_host_model #(.HOLD(5)) rdpc_host_model_inst (.clk_i(clk_i),
        .idle_req_i(idle_req), .in_req_i(in_req), .kill_req_i(kill_req),
        .rst_req_i(rst_req), .cs_req_i(cs_req), .idle_pin_o(idle_pin),
        .in_pin_o(in_pin), .kill_pin_o(kill_pin), .rst_pin_n_o(rst_pin_n),
        .cs_n_o(cs_n));

    rdpc_pin_control #(.IDLE_FLT_CYC(3)) rdpc_pin_control_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
        .rd_data_o(rd_data_o), .parallel_cmd_input_a_i(in_pin[0]),
        .parallel_cmd_input_b_i(in_pin[1]), .idle_pin_i(idle_pin),
        .hardware_reset_pin_n_i(rst_pin_n), .output_kill_pin_i(kill_pin),
        .serial_cs_n_i(cs_n), .pwm_gen_i(pwm), .ch_drive_o(ch),
        .mode_o(mode), .serial_out_en_o(sout_en), .uv_io_det_en_o(uv_io),
        .uv_batt_det_en_o(uv_batt), .internal_reset_o(int_rst));

    // Unit without safety pins: unmask bits stay zero whatever is written
    rdpc_pin_control #(.IDLE_FLT_CYC(3), .HAS_SAFETY_PINS(1'b0))
        rdpc_pin_control_lite_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
        .rd_data_o(), .parallel_cmd_input_a_i(in_pin[0]),
        .parallel_cmd_input_b_i(in_pin[1]), .idle_pin_i(idle_pin),
        .hardware_reset_pin_n_i(rst_pin_n), .output_kill_pin_i(kill_pin),
        .serial_cs_n_i(cs_n), .pwm_gen_i(pwm), .ch_drive_o(ch_lite),
        .mode_o(), .serial_out_en_o(), .uv_io_det_en_o(),
        .uv_batt_det_en_o(), .internal_reset_o(int_rst_lite));

    task chk(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask

    task wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_en_i <= 1'b1;
        @(posedge clk_i);
        wr_en_i <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_en_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_i);
        rd_en_i <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_i) begin
        if (rd_seen) chk("rd_data_o", rd_data_o, exp_q.pop_front());
        rd_seen = rd_en_i;
    end

    task tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        wt(4000);
        err_count++;
        tally_and_finish;
    end

    initial begin
        wt(8);
        rst_n_i <= 1'b1;
        wt(2);
        chk("mode_o", mode, rdpc_pkg::RDPC_SLEEP); // reset mode
        chk("uv enables", {uv_io, uv_batt}, 0); // detectors off
        idle_req <= 1'b1;
        wt(20);
        chk("mode_o", mode, rdpc_pkg::RDPC_IDLE); // sleep left
        rd(`RDPC_OFF_MAP_A, `RDPC_RST_MAP_A); // default select
        rd(`RDPC_OFF_MAP_B, `RDPC_RST_MAP_B); // default select
        rd(8'h20, 32'h0); // unmapped zero
        in_req <= 2'b01;
        wt(12);
        chk("ch_drive_o", ch, 8'h04); // input a route
        in_req <= 2'b11;
        wt(12);
        chk("ch_drive_o", ch, 8'h0c); // both inputs
        in_req <= 2'b01;
        wr(`RDPC_OFF_MAP_A, 32'h81); // new select
        wr(`RDPC_OFF_MAP_PWM0, 32'h10);
        wr(`RDPC_OFF_MAP_PWM1, 32'h20);
        repeat (4) begin
            on_bits = 8'($random(seed));
            pwm <= 2'($random(seed));
            wr(`RDPC_OFF_ON_CMD, {24'h0, on_bits});
            wt(12);
            chk("ch_drive_o", ch,
                on_bits | 8'h81 | {2'b0, pwm, 4'h0}); // or
        end
        wr(`RDPC_OFF_ON_CMD, 32'h0);
        pwm <= 2'h0;
        kill_req <= 1'b1;
        wt(12);
        chk("ch_drive_o", ch, 8'h81); // kill masked
        rd(`RDPC_OFF_PIN_LEVEL, 32'h1d); // kill level seen
        wr(`RDPC_OFF_CTRL, 32'h2);
        wt(4);
        chk("ch_drive_o", ch, 8'h00); // kill active
        chk("lite ch_drive_o", ch_lite, 8'h81); // kill ignored
        kill_req <= 1'b0;
        wt(12);
        chk("ch_drive_o", ch, 8'h81); // kill low
        rst_req <= 1'b1;
        wt(12);
        chk("internal_reset_o", int_rst, 0); // pin masked
        wr(`RDPC_OFF_CTRL, 32'h3);
        wt(4);
        chk("internal_reset_o", int_rst, 1); // reset held
        chk("lite internal_reset_o", int_rst_lite, 0); // reset ignored
        chk("ch_drive_o", ch, 8'h00); // channels off
        rst_req <= 1'b0;
        wt(12);
        chk("ch_drive_o", ch, 8'h04); // defaults back
        rd(`RDPC_OFF_MAP_A, 32'h04); // select default
        wr(`RDPC_OFF_MAP_A, 32'h81); // limp ignores select
        idle_req <= 1'b0;
        cs_req <= 1'b1;
        wt(20);
        chk("mode_o", mode, rdpc_pkg::RDPC_LIMP); // limp entry
        chk("ch_drive_o", ch, 8'h04); // default channel
        chk("serial_out_en_o", sout_en, 1); // awake output on
        rd(`RDPC_OFF_PIN_LEVEL, 32'h11); // monitor in limp
        in_req <= 2'b00;
        wt(20);
        chk("mode_o", mode, rdpc_pkg::RDPC_SLEEP); // sleep entry
        chk("serial_out_en_o", sout_en, 0); // output off
        chk("uv enables", {uv_io, uv_batt}, 0); // detectors off
        rd(`RDPC_OFF_MAP_A, 32'h0); // access refused
        wr(`RDPC_OFF_MAP_A, 32'hff);
        cs_req <= 1'b0;
        idle_req <= 1'b1;
        wt(20);
        rd(`RDPC_OFF_CTRL, 32'h0); // ctrl cleared
        rd(`RDPC_OFF_MAP_A, 32'h04); // select cleared
        wt(3);
        tally_and_finish;
    end
endmodule
